// ==== hdl/fpdio_change.sv ====
// Change detector and pending bits of the watched port.
// Assumes cur is already synchronised; clr is a one-cycle read strobe.
`timescale 1ns/1ps
module fpdio_change #(
  parameter int PW = fpdio_pkg::PORT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic arm,
  input wire logic [PW-1:0] cur,
  input wire logic [PW-1:0] clr,
  output logic [PW-1:0] pend,
  output logic irq,
  output logic evt
);
  import fpdio_pkg::*;

  logic [PW-1:0] prev_r, pend_r, pend_nxt, chg;
  logic irq_r, evt_r;

  // Per-line change; a set in the clearing cycle survives
  assign chg = arm ? (cur ^ prev_r) : '0;
  assign pend_nxt = (pend_r & ~clr) | chg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= PW'(PORT_RST);
      pend_r <= PW'(PEND_RST);
      irq_r <= 1'b0;
      evt_r <= 1'b0;
    end else if (ce) begin
      prev_r <= cur;
      pend_r <= pend_nxt;
      irq_r <= |pend_nxt;
      evt_r <= |chg;
    end
  end

  assign pend = pend_r;
  assign irq = irq_r;
  assign evt = evt_r;

  a_change_sets: assert property (@(posedge clk) disable iff (!nrst)
    ce && arm && (cur != prev_r) |=> irq && evt
      && ((pend & ($past(cur) ^ $past(prev_r))) == ($past(cur) ^ $past(prev_r))))
    else $error("line change did not raise pending");
endmodule

// ==== hdl/fpdio_pkg.sv ====
// Shared constants and types of the four-port digital I/O block.
// Assumes a 32-bit AHB-Lite register slave and one 50 MHz clock.
package fpdio_pkg;
  // Geometry
  localparam int PORTS = 4;
  localparam int PORT_W = 8;
  localparam int DATA_W = 32;
  localparam int OFS_W = 8;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_W32 = 8'h00;
  localparam logic [7:0] OFS_W24 = 8'h04;
  localparam logic [7:0] OFS_W16C0 = 8'h08;
  localparam logic [7:0] OFS_W16C2 = 8'h0c;
  localparam logic [7:0] OFS_W8C0 = 8'h10;
  localparam logic [7:0] OFS_PEND = 8'h20;
  localparam logic [7:0] OFS_DIR = 8'h24;
  localparam logic [7:0] OFS_STAT = 8'h28;
  // Port masks per access width
  localparam logic [3:0] MASK_W32 = 4'hf;
  localparam logic [3:0] MASK_W24 = 4'h7;
  localparam logic [3:0] MASK_W16 = 4'h3;
  localparam logic [3:0] MASK_W8 = 4'h1;
  localparam logic [1:0] SH_C0 = 2'h0;
  localparam logic [1:0] SH_C2 = 2'h2;
  // Status word fields
  localparam int STAT_IRQ = 4;
  localparam int STAT_RDY = 5;
  // Reset values
  localparam logic [3:0] DIR_RST = 4'h0;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // Port watched for changes
  localparam int CHG_PORT = 3;
  // Forced-input cycles: synchroniser depth plus one compare stage
  localparam logic [1:0] FORCE_CYC = 2'h3;
  // Bus codes
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic RESP_OKAY = 1'b0;
  typedef enum logic [1:0] {ST_FORCE, ST_RESTORE, ST_RUN} fpdio_state_t;
endpackage

// ==== hdl/fpdio_port.sv ====
// One 8-line port: input synchroniser and held output value.
// Assumes pins are asynchronous to clk; write strobe comes from clk logic.
`timescale 1ns/1ps
module fpdio_port #(
  parameter int PW = fpdio_pkg::PORT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic isOut,
  input wire logic wrEn,
  input wire logic [PW-1:0] wrData,
  input wire logic [PW-1:0] pinIn,
  output logic [PW-1:0] outVal,
  output logic [PW-1:0] inVal
);
  import fpdio_pkg::*;

  logic [PW-1:0] s1_r, s2_r, out_r;

  if (PW > PORT_W) begin : g_bad
    $error("fpdio_port: PW wider than reset constant");
  end

  // Two-stage synchroniser; s1_r feeds only s2_r
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= PW'(PORT_RST);
      s2_r <= PW'(PORT_RST);
    end else if (ce) begin
      s1_r <= pinIn;
      s2_r <= s1_r;
    end
  end

  // Input ports drop write data, so pins stay undriven
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_r <= PW'(PORT_RST);
    end else if (ce && wrEn && isOut) begin
      out_r <= wrData;
    end
  end

  assign outVal = out_r;
  assign inVal = s2_r;

  // Both stages must have run out of reset, else the reset fill shows
  a_sync_two: assert property (@(posedge clk) disable iff (!nrst)
    $past(ce) && $past(ce, 2) && $past(nrst, 2) |-> inVal == $past(pinIn, 2))
    else $error("input not seen two edges later");
endmodule

// ==== hdl/fpdio_top.sv ====
// Four-port digital I/O block with change interrupt on the fourth port.
// Assumes an AHB-Lite master, pins from outside, savedDir from clk logic.
//
// How it works
// - Thirty-two two-way lines sit in four ports of eight lines each.
// - Direction is set per port, so one enable covers all eight lines.
// - After reset every port is input, then the saved direction is applied.
// - Register views give 8, 16, 24 or 32 bit access over adjacent ports.
// - In a wide view port one takes bits 7:0 and port four bits 31:24.
// - At 16 bits ports one and two form channel 0, three and four channel 2.
// - Any change on the fourth port raises the interrupt, except the one made by a flip of its direction either way.
// - The fourth port flags pin changes as input and value-changing writes as output.
// - An output port reads back the value it drives.
// - An input port ignores write data and its pins stay undriven.
// - The pending view is read only and writes to it do nothing.
// - The pending view holds one bit per line of the fourth port.
// - A single access finishes by itself: a write moves data at once, a read after one wait state.
`timescale 1ns/1ps
module fpdio_top #(
  parameter int NPORT = fpdio_pkg::PORTS,
  parameter int PW = fpdio_pkg::PORT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [fpdio_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [fpdio_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [fpdio_pkg::DATA_W-1:0] hrdata,
  output logic hresp,
  input wire logic [fpdio_pkg::DATA_W-1:0] pinIn,
  output logic [fpdio_pkg::DATA_W-1:0] pinOut,
  output logic [fpdio_pkg::DATA_W-1:0] pinOe,
  input wire logic [fpdio_pkg::PORTS-1:0] savedDir,
  output logic irq,
  output logic portChangeEvent
);
  import fpdio_pkg::*;

  if (NPORT != PORTS || PW != PORT_W) begin : g_bad
    $error("fpdio_top: only four ports of eight lines fit the bus word");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic accept, doWr, doRd;
  logic wrPend_r, rdPend_r, wrWord_r, ready_r;
  logic [OFS_W-1:0] addr_r;
  logic [DATA_W-1:0] rdata_r, rdData, statWord;
  logic hitData, isPend, isDir, isStat;
  logic [1:0] sh;
  logic [3:0] mask;
  logic [4:0] shamt;
  logic [DATA_W-1:0] maskBits, laneWr, portVal, outVal, inVal;
  logic [DATA_W-1:0] oeNxt, oe_r;
  logic [NPORT-1:0] portWe;
  fpdio_state_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [NPORT-1:0] dir_r, dir_nxt;
  logic dirD_r, arm;
  logic [PW-1:0] cur, clr, pend;

  ////////////////////////////////////////////////////////////////////////
  // Bus phases

  // Address phase taken only while the bus is ready
  assign accept = hsel & htrans[1] & hready;
  // Writes land in their data phase; sub-word writes are dropped
  assign doWr = wrPend_r & wrWord_r & hready;
  // Reads run one cycle after their address phase
  assign doRd = rdPend_r;

  // One wait state on reads so a write just before is visible
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      wrWord_r <= 1'b0;
      ready_r <= 1'b1;
      addr_r <= '0;
      rdata_r <= RD_ZERO;
    end else if (ce) begin
      wrPend_r <= accept & hwrite;
      rdPend_r <= accept & ~hwrite;
      if (accept) begin
        addr_r <= haddr[OFS_W-1:0];
        wrWord_r <= (hsize == SIZE_WORD);
      end
      if (accept && !hwrite) begin
        ready_r <= 1'b0;
      end else if (rdPend_r) begin
        ready_r <= 1'b1;
      end
      if (rdPend_r) begin
        rdata_r <= rdData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Each view names a port mask and the first port's lane
  always_comb begin
    hitData = 1'b0;
    isPend = 1'b0;
    isDir = 1'b0;
    isStat = 1'b0;
    sh = SH_C0;
    mask = 4'h0;
    if (addr_r == OFS_W32) begin
      hitData = 1'b1;
      mask = MASK_W32;
    end else if (addr_r == OFS_W24) begin
      hitData = 1'b1;
      mask = MASK_W24;
    end else if (addr_r == OFS_W16C0) begin
      hitData = 1'b1;
      mask = MASK_W16;
    end else if (addr_r == OFS_W16C2) begin
      hitData = 1'b1;
      sh = SH_C2;
      mask = MASK_W16 << SH_C2;
    end else if (addr_r[7:4] == OFS_W8C0[7:4] && addr_r[1:0] == 2'b00) begin
      hitData = 1'b1;
      sh = addr_r[3:2];
      mask = MASK_W8 << addr_r[3:2];
    end else if (addr_r == OFS_PEND) begin
      isPend = 1'b1;
    end else if (addr_r == OFS_DIR) begin
      isDir = 1'b1;
    end else if (addr_r == OFS_STAT) begin
      isStat = 1'b1;
    end
  end

  // Lane shift; the view's low byte is always its first port
  assign shamt = {sh, 3'b000};
  assign laneWr = hwdata << shamt;
  assign portWe = {NPORT{doWr & hitData}} & mask;

  ////////////////////////////////////////////////////////////////////////
  // Ports

  genvar i;
  for (i = 0; i < NPORT; i++) begin : g_port
    // Whole-port masks and enables
    assign maskBits[i*PW +: PW] = {PW{mask[i]}};
    assign oeNxt[i*PW +: PW] = {PW{dir_nxt[i]}};
    // Output ports read what they drive
    assign portVal[i*PW +: PW] = dir_r[i] ? outVal[i*PW +: PW] : inVal[i*PW +: PW];

    fpdio_port #(.PW(PW)) u_port (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .isOut(dir_r[i]),
      .wrEn(portWe[i]),
      .wrData(laneWr[i*PW +: PW]),
      .pinIn(pinIn[i*PW +: PW]),
      .outVal(outVal[i*PW +: PW]),
      .inVal(inVal[i*PW +: PW])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  assign statWord = {{(DATA_W-STAT_RDY-1){1'b0}}, state_r == ST_RUN, irq, dir_r};
  // Unmapped words read as zero with an OKAY answer
  assign rdData = hitData ? ((portVal & maskBits) >> shamt)
                : isPend ? {{(DATA_W-PW){1'b0}}, pend}
                : isDir ? {{(DATA_W-NPORT){1'b0}}, dir_r}
                : isStat ? statWord
                : RD_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Direction sequencing

  // Forced input covers synchroniser fill, so no false change at start
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    case (state_r)
      ST_FORCE: begin
        dir_nxt = DIR_RST;
        if (cnt_r == FORCE_CYC - 2'h1) begin
          state_nxt = ST_RESTORE;
        end else begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end
      ST_RESTORE: begin
        dir_nxt = savedDir;
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (doWr && isDir) begin
          dir_nxt = hwdata[NPORT-1:0];
        end
      end
      default: begin
        state_nxt = ST_FORCE;
      end
    endcase
  end

  // Enables follow the next direction so pins and dir_r agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_FORCE;
      cnt_r <= 2'h0;
      dir_r <= DIR_RST;
      oe_r <= '0;
      dirD_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      oe_r <= oeNxt;
      dirD_r <= dir_r[CHG_PORT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Change detection on the fourth port

  // Compare disarmed for the cycle the value source flips
  assign arm = (state_r == ST_RUN) && (dir_r[CHG_PORT] == dirD_r);
  assign cur = portVal[CHG_PORT*PW +: PW];
  // Pending view never takes writes; reads clear what they return
  assign clr = (doRd && isPend) ? pend : '0;

  fpdio_change #(.PW(PW)) u_change (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .arm(arm),
    .cur(cur),
    .clr(clr),
    .pend(pend),
    .irq(irq),
    .evt(portChangeEvent)
  );

  // Output drive
  assign hreadyout = ready_r;
  assign hrdata = rdata_r;
  assign hresp = RESP_OKAY;
  assign pinOut = outVal;
  assign pinOe = oe_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rdAccept;
    ce && accept && !hwrite;
  endsequence

  sequence s_rdExec;
    ce && rdPend_r;
  endsequence

  sequence s_wrExec;
    ce && doWr;
  endsequence

  a_read_completes: assert property (
    s_rdAccept ##1 ce |-> !hreadyout ##1 hreadyout)
    else $error("read did not finish after one wait");

  a_out_readback: assert property (
    s_rdExec ##0 addr_r == OFS_W32 |=> ((hrdata ^ $past(pinOut)) & $past(pinOe)) == 0)
    else $error("output port read back wrong value");

  a_chan2_pair: assert property (
    s_rdExec ##0 addr_r == OFS_W16C2 |=> hrdata == {16'h0000, $past(portVal[31:16])})
    else $error("channel 2 view not ports three and four");

  a_input_unwritten: assert property (
    ce && doWr |=> ((pinOut ^ $past(pinOut)) & ~$past(pinOe)) == 0)
    else $error("write changed an input port");

  a_pend_reported: assert property (
    s_rdExec ##0 isPend |=> hrdata == {24'h000000, $past(pend)})
    else $error("pending view read wrong");

  a_pend_cleared: assert property (
    s_rdExec ##0 isPend |=> portChangeEvent || (pend == 0 && !irq))
    else $error("read did not clear pending");

  a_pend_readonly: assert property (
    ce && doWr && isPend |=> (pend & $past(pend)) == $past(pend))
    else $error("write altered pending view");

  a_irq_level: assert property (
    irq == (|pend))
    else $error("interrupt does not match pending");

  a_force_input: assert property (
    state_r == ST_FORCE |-> dir_r == DIR_RST && pinOe == 0)
    else $error("port not input before restore");

  a_restore_dir: assert property (
    ce && state_r == ST_RESTORE |=> dir_r == $past(savedDir) && state_r == ST_RUN)
    else $error("saved direction not applied");

  a_whole_port: assert property (
    pinOe == {{8{pinOe[24]}}, {8{pinOe[16]}}, {8{pinOe[8]}}, {8{pinOe[0]}}})
    else $error("port enables split within a port");

  a_oe_follows_dir: assert property (
    pinOe == {{8{dir_r[3]}}, {8{dir_r[2]}}, {8{dir_r[1]}}, {8{dir_r[0]}}})
    else $error("enables do not match direction bits");

  a_dir_write: assert property (
    s_wrExec ##0 isDir && state_r == ST_RUN |=> dir_r == $past(hwdata[3:0]))
    else $error("direction write not applied");

  a_write_no_wait: assert property (
    ce && accept && hwrite |=> hreadyout)
    else $error("write phase inserted a wait");

  a_wide_order: assert property (
    s_rdExec ##0 addr_r == OFS_W32 |=> hrdata == $past(portVal))
    else $error("wide view lanes out of order");

  a_chan0_pair: assert property (
    s_rdExec ##0 addr_r == OFS_W16C0 |=> hrdata == {16'h0000, $past(portVal[15:0])})
    else $error("channel 0 view not ports one and two");

  a_byte_view: assert property (
    s_rdExec ##0 addr_r == OFS_W8C0 |=> hrdata == {24'h000000, $past(portVal[7:0])})
    else $error("first byte view not port one");
endmodule

// ==== testbench/fpdio_pin_model.sv ====
// Far-side model: outside sources on the 32 lines.
// Assumes pinOe is high where the block drives a line.
`timescale 1ns/1ps
module fpdio_pin_model (
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOe,
  input wire logic [31:0] extVal,
  output logic [31:0] pinIn
);
  // Block drive wins on a line, else the outside level shows
  assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule

// ==== testbench/tb.sv ====
// Bench for the four-port I/O block: AHB-Lite master and pin sources.
// Assumes one 50 MHz clock and the pin model beside the block.
`timescale 1ns/1ps
module tb;
  import fpdio_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, portChangeEvent;
  logic [31:0] hrdata, pinIn, pinOut, pinOe, q;
  logic [3:0] savedDir = 4'h5;
  logic [31:0] extVal = 32'hd4c3b2a1;
  int failures = 0;
  int totalChecks = 0;
  int evtCount = 0;

  ////////////////////////////////////////////////////////////////////
  // Clock, event counter and watchdog
  always #10 clk = ~clk;
  always @(posedge clk) if (portChangeEvent === 1'b1) evtCount++;
  initial begin
    #100000;
    failures++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////
  // Block and outside sources; hready loops back from the one slave
  fpdio_top u_fpdio_top (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .savedDir(savedDir), .irq(irq),
    .portChangeEvent(portChangeEvent));
  fpdio_pin_model u_fpdio_pin_model (.pinOut(pinOut), .pinOe(pinOe),
    .extVal(extVal), .pinIn(pinIn));

  ////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic waitRdy(output int n);
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      @(posedge clk);
    end
  endtask

  // One single word transfer; ends at the data-phase edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy(n);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    waitRdy(n);
    q = hrdata;
    chk(n, w ? 32'h0 : 32'h1, "data phase waits");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(a, 1'b0, 32'h0);
    chk(q, e, m);
  endtask

  // Pins settle after the write edge; realign to an edge afterwards
  task automatic pinChk(input logic [31:0] e, input string m);
    #1 chk(pinOut, e, m);
    @(posedge clk);
  endtask

  task automatic doReset(input logic [3:0] sd, input logic [31:0] oe);
    savedDir <= sd;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    chk(pinOe, 32'h0, "oe in reset");
    nrst <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      #1 chk(pinOe, 32'h0, "forced input");
    end
    @(posedge clk);
    #1 chk(pinOe, oe, "restored dir");
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic tReset();
    doReset(4'h5, 32'h00ff00ff);
    chk(irq, 32'h0, "no irq at start");
    rd(OFS_STAT, 32'h25, "status");
  endtask

  // Wide write, then every data view and one unmapped word read back to back
  task automatic tViews();
    logic [7:0] a [9] = '{OFS_W32, OFS_W24, OFS_W16C0, OFS_W16C2, OFS_W8C0,
      8'h14, 8'h18, 8'h1c, 8'h40};
    logic [31:0] e [9] = '{32'hd433b211, 32'h0033b211, 32'h0000b211,
      32'h0000d433, 32'h11, 32'hb2, 32'h33, 32'hd4, 32'h0};
    bus(OFS_W32, 1'b1, 32'h44332211);
    pinChk(32'h00330011, "wide write");
    for (int i = 0; i < 9; i++) begin
      rd(a[i], e[i], "view read");
    end
  endtask

  task automatic tNarrow();
    bus(OFS_W16C2, 1'b1, 32'hffff5566);
    pinChk(32'h00660011, "ch2 write");
    bus(8'h14, 1'b1, 32'h77);
    pinChk(32'h00660011, "input port write");
    rd(8'h14, 32'hb2, "input port read");
  endtask

  // Pin change on the watched port while it is input
  task automatic tChgIn();
    evtCount = 0;
    extVal <= 32'h55c3b2a1;
    @(posedge clk);
    #1 chk(irq, 32'h0, "irq too early");
    repeat (2) @(posedge clk);
    #1 chk(irq, 32'h1, "irq on pin change");
    @(posedge clk);
    rd(OFS_PEND, 32'h81, "pending lines");
    #1 chk(irq, 32'h0, "irq after clear");
    chk(evtCount, 32'h1, "one event");
    @(posedge clk);
    bus(OFS_PEND, 1'b1, 32'hff);
    rd(OFS_PEND, 32'h0, "pending read only");
  endtask

  // Enable low holds the synchroniser, so a pin change waits for it
  task automatic tFreeze();
    ce <= 1'b0;
    extVal <= 32'h66c3b2a1;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    #1 chk(irq, 32'h0, "frozen by enable");
    repeat (3) @(posedge clk);
    #1 chk(irq, 32'h1, "irq after enable");
    @(posedge clk);
    rd(OFS_PEND, 32'h33, "pending after freeze");
  endtask

  // Watched port as output: only value-changing writes count
  task automatic tChgOut();
    bus(OFS_DIR, 1'b1, 32'hd);
    repeat (2) @(posedge clk);
    #1 chk(pinOe, 32'hffff00ff, "dir write");
    @(posedge clk);
    rd(OFS_PEND, 32'h0, "no change on dir flip");
    bus(8'h1c, 1'b1, 32'h5a);
    @(posedge clk);
    #1 chk(irq, 32'h1, "irq on write");
    @(posedge clk);
    rd(OFS_PEND, 32'h5a, "changed lines");
    rd(OFS_W32, 32'h5a66b211, "mixed readback");
    bus(8'h1c, 1'b1, 32'h5a);
    repeat (2) @(posedge clk);
    #1 chk(irq, 32'h0, "same value write");
    @(posedge clk);
  endtask

  task automatic tReload();
    doReset(4'h8, 32'hff000000);
    rd(OFS_STAT, 32'h28, "status reload");
  endtask

  ////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic summarize();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    tReset();
    tViews();
    tNarrow();
    tChgIn();
    tFreeze();
    tChgOut();
    tReload();
    summarize();
  end
endmodule
